// [common/plec_map.svh]
// constants for the parity, lock and system-error control block
`ifndef PLEC_MAP_SVH
`define PLEC_MAP_SVH

// lock tracker state codes (one-hot)
`define PLEC_LK_OPEN_CODE    2'h1
`define PLEC_LK_HELD_CODE    2'h2

// reset values of the registered outputs
`define PLEC_PAR_RST         1'h0
`define PLEC_PAR_OE_RST      1'h0
`define PLEC_NMI_RST         1'h0
`define PLEC_SYNC_RST        2'h0

// field positions of the parity source word {cbe, ad}
`define PLEC_AD_LSB          0
`define PLEC_AD_MSB          31
`define PLEC_CBE_LSB         32
`define PLEC_CBE_MSB         35

// timing: parity trails its phase by this many bus clocks
`define PLEC_PAR_DELAY_CLK   1
// reset release passes this many flip-flops
`define PLEC_RST_SYNC_STAGES 2

`endif

// [common/plec_par_if.sv]
// carrier between the control top and its parity generator
`timescale 1ns/1ps
`default_nettype none
interface plec_par_if;
   import plec_pkg::*;
   logic          srst_n;   // synchronised reset, active low
   plec_par_src_t src;      // {cbe_n, ad} as seen on the bus
   logic          drive;    // we own this phase, parity due next clock
   logic          par;      // registered even parity
   logic          par_en;   // registered drive request for the pin

   modport core (output srst_n, output src, output drive,
                 input par, input par_en);
   modport gen  (input srst_n, input src, input drive,
                 output par, output par_en);
endinterface : plec_par_if
`default_nettype wire

// [common/plec_pkg.sv]
// types shared by the parity, lock and system-error control block
`default_nettype none
package plec_pkg;
`include "plec_map.svh"

   // lock tracker states, one-hot
   typedef enum logic [1:0] {
      PLEC_LK_OPEN = `PLEC_LK_OPEN_CODE,
      PLEC_LK_HELD = `PLEC_LK_HELD_CODE
   } plec_lock_t;

   // parity source width: 32 address/data lines plus 4 command lines
   typedef logic [`PLEC_CBE_MSB:`PLEC_AD_LSB] plec_par_src_t;

endpackage : plec_pkg
`default_nettype wire

// [logic/plec_par.sv]
// delayed even parity generator for the bus parity pin
`timescale 1ns/1ps
`default_nettype none
`include "plec_map.svh"
module plec_par (
   // clock
   input  wire logic clk,
   // carrier to the control top
   plec_par_if.gen   pif
);
   import plec_pkg::*;

   logic par_q;
   logic par_d;
   logic en_q;
   logic en_d;

   // even parity: the pin plus all 36 lines holds an even count of ones
   always_comb begin
      par_d = ^pif.src;                          // see RQ1
      en_d  = pif.drive;                         // see RQ2 see RQ3
      if (!pif.srst_n) begin
         par_d = `PLEC_PAR_RST;
         en_d  = `PLEC_PAR_OE_RST;               // see RQ13
      end
   end

   // one register stage gives the one-clock lag
   always_ff @(posedge clk) begin
      par_q <= par_d;
      en_q  <= en_d;
   end

   assign pif.par    = par_q;
   assign pif.par_en = en_q;
endmodule // plec_par
`default_nettype wire

// [logic/plec_sync.sv]
// reset release synchroniser: asynchronous assert, clocked release
`timescale 1ns/1ps
`default_nettype none
`include "plec_map.svh"
module plec_sync (
   // clock and raw reset pin
   input  wire logic clk,
   input  wire logic arst_n,
   // synchronised reset
   output logic      srst_n
);
   import plec_pkg::*;

   logic [`PLEC_RST_SYNC_STAGES-1:0] stage_q;
   logic [`PLEC_RST_SYNC_STAGES-1:0] stage_d;

   // shift a one in; only the last stage is read outside
   always_comb begin
      stage_d = {stage_q[`PLEC_RST_SYNC_STAGES-2:0], 1'b1};
   end

   // assertion clears at once, so state cannot run on a half-reset bus
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         stage_q <= `PLEC_SYNC_RST;
      end else begin
         stage_q <= stage_d;
      end
   end

   assign srst_n = stage_q[`PLEC_RST_SYNC_STAGES-1];
endmodule // plec_sync
`default_nettype wire

// [logic/plec_top.sv]
// parity, bus lock and system-error control for the bus side of a bridge
//
// How it works
// RQ1: parity is even over the 32 address/data and 4 command lines.
// RQ2: our own address phases get parity one clock later.
// RQ3: data parity driven one clock late only for our writes or target reads.
// RQ4: any agent may pulse the system-error line active.
// RQ5: a sampled active system-error line raises an NMI request.
// RQ6: the lock line is an input only, never driven.
// RQ7: addressed as target with lock negated in address phase: become locked.
// RQ8: stay locked until lock and frame are both seen negated together.
// RQ9: while locked, other masters' accesses end with target retry.
// RQ10: every bus signal is sampled on the rising clock edge.
// RQ11: logic must work with a 25 or 33 MHz bus clock.
// RQ12: bus reset puts every tri-state output into high impedance.
// RQ13: bus reset returns every register to its default.
// RQ14: bus reset may assert or negate asynchronously to the clock.
// RQ15: reset source holds reset over 1us and negates it cleanly.
// RQ16: reset release is synchronised before the state machines run.
`timescale 1ns/1ps
`default_nettype none
`include "plec_map.svh"
module plec_top (
   // bus clock and bus reset pin
   input  wire logic                clk,
   input  wire logic                bus_reset_n,
   // bus pins, sampled on the rising edge
   input  wire logic [31:0]         ad_in,
   input  wire logic [3:0]          cbe_in_n,
   input  wire logic                frame_n,
   input  wire logic                bus_lock_in_n,
   input  wire logic                serr_n,
   // parity pin, output with enable
   output logic                     par_out,
   output logic                     par_oe,
   // phase flags from the bridge's bus state machine
   input  wire logic                mst_addr_phase,
   input  wire logic                mst_write_data,
   input  wire logic                tgt_read_data,
   input  wire logic                tgt_addr_hit,
   // answers to the bridge and the processor
   output logic                     tgt_retry,
   output logic                     locked,
   output logic                     nmi_req
);
   import plec_pkg::*;

   plec_par_if pif ();

   logic       srst_n;
   plec_lock_t lock_q;
   plec_lock_t lock_d;
   logic       nmi_q;
   logic       nmi_d;
   logic       lock_hit;
   logic       lock_free;

   // ------------------------------------------------------------------
   // reset: raw pin only gates the enables, state uses the clean release
   // ------------------------------------------------------------------
   plec_sync u_sync (
      .clk    (clk),
      .arst_n (bus_reset_n),                     // see RQ14
      .srst_n (srst_n)                           // see RQ16
   );

   // ------------------------------------------------------------------
   // parity: all inputs are bus-synchronous and taken on the rising edge,
   // so no extra stages are added; the one-stage lag keeps the figure
   // independent of clock rate, which is why 25 and 33 MHz both work
   // ------------------------------------------------------------------
   assign pif.srst_n = srst_n;
   assign pif.src    = {cbe_in_n, ad_in};        // see RQ1 see RQ10
   // own address phase, write data as initiator or read data as target; else hands off
   assign pif.drive  = mst_addr_phase            // see RQ2
                     | mst_write_data            // see RQ3
                     | tgt_read_data;            // see RQ3 see RQ11

   plec_par u_par (
      .clk (clk),
      .pif (pif.gen)
   );

   // raw pin gating releases the pin at once, not at the next clock edge
   always_comb begin
      par_out = pif.par;
      par_oe  = pif.par_en & bus_reset_n;        // see RQ12
   end

   // ------------------------------------------------------------------
   // lock tracking; the lock line has no output path at all (see RQ6)
   // ------------------------------------------------------------------
   // an access that finds lock negated in its address phase opens a lock
   assign lock_hit  = tgt_addr_hit & bus_lock_in_n;   // see RQ7
   // lock and frame both idle in one sample ends it
   assign lock_free = bus_lock_in_n & frame_n;        // see RQ8

   // next lock state; set and clear cannot meet since set is tested only in OPEN and clear only in HELD
   always_comb begin
      lock_d = lock_q;
      unique case (lock_q)
         PLEC_LK_OPEN: begin
            if (lock_hit) begin
               lock_d = PLEC_LK_HELD;            // see RQ7
            end
         end
         PLEC_LK_HELD: begin
            if (lock_free) begin
               lock_d = PLEC_LK_OPEN;            // see RQ8
            end
         end
         default: begin
            lock_d = PLEC_LK_OPEN;               // upset codes recover
         end
      endcase
      if (!srst_n) begin
         lock_d = PLEC_LK_OPEN;                  // see RQ13
      end
   end

   // lock state register
   always_ff @(posedge clk) begin
      lock_q <= lock_d;
   end

   assign locked = (lock_q == PLEC_LK_HELD);

   // the owner re-enters with lock negated; anyone else finds it asserted
   always_comb begin
      tgt_retry = locked & tgt_addr_hit & ~bus_lock_in_n; // see RQ9
   end

   // ------------------------------------------------------------------
   // system error: every sampled active clock gives one NMI request cycle;
   // the processor side latches it, so no stretch is kept here (see RQ4)
   // ------------------------------------------------------------------
   always_comb begin
      nmi_d = ~serr_n;                           // see RQ5
      if (!srst_n) begin
         nmi_d = `PLEC_NMI_RST;                  // see RQ13
      end
   end

   // request register
   always_ff @(posedge clk) begin
      nmi_q <= nmi_d;
   end

   assign nmi_req = nmi_q;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!srst_n);

   // our address phase, then our parity on the next clock
   sequence s_own_addr;
      mst_addr_phase;
   endsequence

   // a phase in which we own the data lines
   sequence s_own_data;
      mst_write_data || tgt_read_data;
   endsequence

   // nobody asked us to drive
   sequence s_not_ours;
      !mst_addr_phase && !mst_write_data && !tgt_read_data;
   endsequence

   // target hit with lock negated: the opening move of a lock
   sequence s_lock_open;
      !locked && tgt_addr_hit && bus_lock_in_n;
   endsequence

   // both lines idle in one sample
   sequence s_release;
      locked && bus_lock_in_n && frame_n;
   endsequence

   // address parity follows one clock later and matches the lines
   property p_par_addr;
      s_own_addr ##0 bus_reset_n |=>
         par_oe && (par_out == ^{$past(cbe_in_n), $past(ad_in)});
   endproperty
   a_par_addr: assert property (p_par_addr) // see RQ2
      else $error("address parity missing or wrong one clock later");

   // data parity driven one clock late for our own data phases
   property p_par_data;
      s_own_data ##0 bus_reset_n |=> par_oe;
   endproperty
   a_par_data: assert property (p_par_data) // see RQ3
      else $error("data parity not driven after own data phase");

   // not ours means the pin is left to the other party
   property p_par_quiet;
      s_not_ours |=> !par_oe;
   endproperty
   a_par_quiet: assert property (p_par_quiet) // see RQ3
      else $error("parity driven for a phase we do not own");

   // pin plus sampled lines always hold an even number of ones
   property p_par_even;
      par_oe |-> (^{par_out, $past(cbe_in_n), $past(ad_in)}) == 1'b0;
   endproperty
   a_par_even: assert property (p_par_even) // see RQ1
      else $error("parity is not even over address and command lines");

   // a sampled system error gives an NMI request on the next clock
   property p_nmi_set;
      !serr_n |=> nmi_req;
   endproperty
   a_nmi_set: assert property (p_nmi_set) // see RQ5
      else $error("system error sampled without NMI request");

   // no system error, no NMI request
   property p_nmi_cause;
      nmi_req |-> $past(!serr_n);
   endproperty
   a_nmi_cause: assert property (p_nmi_cause) // see RQ5
      else $error("NMI request without a sampled system error");

   // the opening move locks us one clock later; holding is left to p_lock_hold
   property p_lock_set;
      s_lock_open |=> locked;
   endproperty
   a_lock_set: assert property (p_lock_set) // see RQ7
      else $error("lock not taken after target hit with lock negated");

   // release frees us on the next clock
   property p_lock_clr;
      s_release |=> !locked;
   endproperty
   a_lock_clr: assert property (p_lock_clr) // see RQ8
      else $error("lock kept after lock and frame both negated");

   // without a release the lock still stands on the next clock
   property p_lock_hold;
      locked && !(bus_lock_in_n && frame_n) |=> locked;
   endproperty
   a_lock_hold: assert property (p_lock_hold) // see RQ8
      else $error("lock dropped without lock and frame negated");

   // the lock only appears through an opening move
   property p_lock_cause;
      $rose(locked) |-> $past(tgt_addr_hit && bus_lock_in_n);
   endproperty
   a_lock_cause: assert property (p_lock_cause) // see RQ7
      else $error("lock taken without a target hit with lock negated");

   // a foreign access to a locked target is retried in that cycle
   property p_retry;
      locked && tgt_addr_hit && !bus_lock_in_n |-> tgt_retry;
   endproperty
   a_retry: assert property (p_retry) // see RQ9
      else $error("foreign access to locked target not retried");

   // retry only ever answers an access while locked
   property p_retry_cause;
      tgt_retry |-> locked && tgt_addr_hit;
   endproperty
   a_retry_cause: assert property (p_retry_cause) // see RQ9
      else $error("retry given while not locked or not addressed");

   // reset pin floats the parity pin in the same cycle
   property p_rst_hiz;
      disable iff (1'b0)
      !bus_reset_n |-> !par_oe;
   endproperty
   a_rst_hiz: assert property (p_rst_hiz) // see RQ12
      else $error("parity pin driven during bus reset");

   // during synchronised reset the lock, NMI request and parity enable return to defaults
   property p_rst_regs;
      disable iff (1'b0)
      !srst_n |=> !locked && !nmi_req && !pif.par_en;
   endproperty
   a_rst_regs: assert property (p_rst_regs) // see RQ13
      else $error("state not at default after reset");

   // two edges with the pin high move the release through both stages,
   // so the third edge already sees the state out of reset
   property p_rst_release;
      disable iff (1'b0)
      !bus_reset_n ##1 bus_reset_n [*3] |-> srst_n;
   endproperty
   a_rst_release: assert property (p_rst_release) // see RQ16
      else $error("reset release not synchronised in two clocks");

   // the first two edges with the pin high still see reset held
   property p_rst_early;
      disable iff (1'b0)
      !bus_reset_n ##1 bus_reset_n [*2] |-> !srst_n;
   endproperty
   a_rst_early: assert property (p_rst_early) // see RQ16
      else $error("reset released without synchronising stages");

endmodule // plec_top
`default_nettype wire

// [tb/plec_bus_model.sv]
// model of the other bus agents: address/data, command, frame, lock, error
`timescale 1ns/1ps
`default_nettype none
module plec_bus_model (
   // bus clock
   input  wire logic   clk,
   // lines driven by the other agents
   output logic [31:0] ad_in,
   output logic [3:0]  cbe_in_n,
   output logic        frame_n,
   output logic        bus_lock_in_n,
   output logic        serr_n
);
   // idle at time zero; frame, lock and error lines rest high on pull-ups
   initial begin
      ad_in         = 32'h5a5a_a5a5;
      cbe_in_n      = 4'ha;
      frame_n       = 1'h1;
      bus_lock_in_n = 1'h1;
      serr_n        = 1'h1;
   end

   // one clock of activity, called just after a falling edge
   task automatic put(input logic [31:0] ad, input logic [3:0] cbe,
                      input logic fr_n, input logic lk_n, input logic se_n);
      ad_in         = ad;
      cbe_in_n      = cbe;
      frame_n       = fr_n;
      bus_lock_in_n = lk_n;     // lock owner or foreign master
      serr_n        = se_n;     // any agent may pulse it
   endtask

   // nobody drives: show the inverse so stale data never looks valid
   task automatic release_bus();
      ad_in         = ~ad_in;
      cbe_in_n      = ~cbe_in_n;
      frame_n       = 1'h1;
      bus_lock_in_n = 1'h1;
      serr_n        = 1'h1;
   endtask
endmodule // plec_bus_model
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the parity, lock and system-error control
`timescale 1ns/1ps
`default_nettype none
module tb;
   import plec_pkg::*;
   logic        clk = 1'h0;
   logic        bus_reset_n = 1'h0;
   logic [31:0] ad_in;
   logic [3:0]  cbe_in_n;
   logic        frame_n, bus_lock_in_n, serr_n;
   logic        par_out, par_oe, tgt_retry, locked, nmi_req;
   logic        mst_addr_phase = 1'h0;
   logic        mst_write_data = 1'h0;
   logic        tgt_read_data  = 1'h0;
   logic        tgt_addr_hit   = 1'h0;
   int          n_errors = 0;
   int          n_compared = 0;
   logic [31:0] seed = 32'h178;
   // lock table rows: hit, frame_n, lock_n, retry now, locked after
   logic [4:0]  lk_tab [8] = '{5'b10101, 5'b10011, 5'b10101, 5'b01001,
                               5'b00101, 5'b01100, 5'b10000, 5'b10101};

   // 4 ns period
   always #2 clk = ~clk;

   plec_bus_model model_u (.clk(clk), .ad_in(ad_in), .cbe_in_n(cbe_in_n),
      .frame_n(frame_n), .bus_lock_in_n(bus_lock_in_n), .serr_n(serr_n));

   plec_top dut_u (.clk(clk), .bus_reset_n(bus_reset_n), .ad_in(ad_in),
      .cbe_in_n(cbe_in_n), .frame_n(frame_n), .bus_lock_in_n(bus_lock_in_n),
      .serr_n(serr_n), .par_out(par_out), .par_oe(par_oe),
      .mst_addr_phase(mst_addr_phase), .mst_write_data(mst_write_data),
      .tgt_read_data(tgt_read_data), .tgt_addr_hit(tgt_addr_hit),
      .tgt_retry(tgt_retry), .locked(locked), .nmi_req(nmi_req));

   // xorshift keeps the run repeatable
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // even parity: pin plus 36 lines hold an even count of ones
   function automatic logic epar(input logic [3:0] cbe,
                                 input logic [31:0] ad);
      logic p;
      p = 1'h0;
      for (int i = 0; i < 32; i++) p = p ^ ad[i];
      for (int i = 0; i < 4; i++) p = p ^ cbe[i];
      return p;
   endfunction

   // single-bit compare, case equality so an unknown never matches
   task automatic chk(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // one bus clock of stimulus, applied on the falling edge
   task automatic step(input logic ma, input logic mw, input logic tr,
                       input logic hit, input logic [31:0] ad,
                       input logic [3:0] cbe, input logic fr_n,
                       input logic lk_n, input logic se_n);
      @(negedge clk);
      mst_addr_phase = ma;
      mst_write_data = mw;
      tgt_read_data  = tr;
      tgt_addr_hit   = hit;
      model_u.put(ad, cbe, fr_n, lk_n, se_n);
   endtask

   // hold reset 16 clocks with requests pending, then release on a low clock
   task automatic hold_reset();
      bus_reset_n = 1'h0;
      step(1'h1, 1'h1, 1'h0, 1'h1, rnd(), 4'h3, 1'h0, 1'h1, 1'h0);
      repeat (16) @(negedge clk);
      chk(par_oe, 1'h0);
      chk(locked, 1'h0);
      chk(nmi_req, 1'h0);
      bus_reset_n = 1'h1; // one clean edge
      mst_addr_phase = 1'h0;
      mst_write_data = 1'h0;
      tgt_addr_hit   = 1'h0;
      model_u.release_bus();
   endtask

   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // watchdog: the whole run needs well under 400 clocks
   initial begin
      #20000;
      n_errors++;
      $display("watchdog expired before the tests ended");
      tally_and_finish();
   end

   // main sequence
   initial begin
      logic [31:0] r, ad;
      logic [3:0]  cbe;
      logic        own;
      hold_reset();
      repeat (2) @(negedge clk); // state machines run from the third edge

      // random owned and foreign phases back to back, with error pulses
      for (int i = 0; i < 64; i++) begin
         r   = rnd();
         ad  = (i == 0) ? 32'h0 : (i == 1) ? 32'hffff_ffff : rnd();
         cbe = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : r[11:8];
         own = r[0] | r[1] | r[2];
         step(r[0], r[1], r[2], 1'h0, ad, cbe, r[7], 1'h1, r[5] | r[6]);
         @(posedge clk);
         #1;
         chk(par_oe, own);
         if (own) chk(par_out, epar(cbe, ad));
         chk(nmi_req, ~(r[5] | r[6]));
      end
      $display("test parity and error done");

      // lock set, foreign retry, owner passes, clear only on both negated
      foreach (lk_tab[i]) begin
         step(1'h0, 1'h0, 1'h0, lk_tab[i][4], rnd(), 4'h7, lk_tab[i][3],
              lk_tab[i][2], 1'h1);
         #1;
         chk(tgt_retry, lk_tab[i][1]);
         @(posedge clk);
         #1;
         chk(locked, lk_tab[i][0]);
      end
      $display("test lock done");

      // asynchronous reset in mid-phase while locked
      step(1'h1, 1'h0, 1'h0, 1'h0, rnd(), 4'h5, 1'h0, 1'h1, 1'h1);
      @(posedge clk);
      #1;
      chk(par_oe, 1'h1);
      bus_reset_n = 1'h0;
      #0.3;
      chk(par_oe, 1'h0);
      hold_reset();
      step(1'h0, 1'h0, 1'h0, 1'h1, rnd(), 4'h1, 1'h0, 1'h1, 1'h0);
      @(posedge clk);
      #1;
      chk(locked, 1'h0);
      chk(nmi_req, 1'h0);
      step(1'h0, 1'h0, 1'h0, 1'h0, rnd(), 4'h1, 1'h1, 1'h1, 1'h1);
      step(1'h0, 1'h0, 1'h0, 1'h1, rnd(), 4'h1, 1'h0, 1'h1, 1'h0);
      @(posedge clk);
      #1;
      chk(locked, 1'h1);
      chk(nmi_req, 1'h1);
      $display("test reset done");
      tally_and_finish();
   end
endmodule // tb
`default_nettype wire
